/* lsc_pkg.sv */
package lsc_pkg;

  // ---------------------------------------------------------------
  // Protection status word layout
  // ---------------------------------------------------------------
  localparam int        PROTECTION_TRIP_STATUS_W          = 8;
  localparam int        BIT_OVER_POWER  = 0;
  localparam int        BIT_OVER_TEMP   = 1;
  localparam int        BIT_OVER_VOLT   = 2;
  localparam int        BIT_OVER_CURR   = 3;
  localparam logic [7:0] PROTECTION_TRIP_STATUS_RESET     = 8'h00;
  localparam int        ERR_W           = 8;
  localparam logic [7:0] ERR_RESET      = 8'h00;

  // ---------------------------------------------------------------
  // Reply characters
  // ---------------------------------------------------------------
  localparam logic [7:0] ASCII_ZERO     = 8'h30;
  localparam logic [7:0] ASCII_ONE      = 8'h31;
  localparam int        REPLY_MAX       = 3;

  // ---------------------------------------------------------------
  // Commands and modes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    LSC_CMD_NONE,
    LSC_CMD_LEVEL_HIGH,
    LSC_CMD_LEVEL_LOW,
    LSC_CMD_LEVEL_QUERY,
    LSC_CMD_DYN_ON,
    LSC_CMD_DYN_OFF,
    LSC_CMD_DYN_QUERY,
    LSC_CMD_CLEAR,
    LSC_CMD_FAIL_QUERY,
    LSC_CMD_PROTECTION_TRIP_STATUS_QUERY
  } lsc_cmd_e;

  typedef enum logic [1:0] {
    LSC_MODE_CC,
    LSC_MODE_CR,
    LSC_MODE_CV,
    LSC_MODE_CP
  } lsc_mode_e;

  typedef enum logic [1:0] {
    LSC_SP_CURRENT,
    LSC_SP_RESISTANCE,
    LSC_SP_VOLTAGE,
    LSC_SP_POWER
  } lsc_sp_e;

  // Trip events from the load stage, one-cycle pulses or levels
  typedef struct packed {
    logic over_current_trip;
    logic over_voltage_trip;
    logic over_temp_trip;
    logic over_power_trip;
  } lsc_trip_s;

  // Reply: up to three ASCII characters, count of valid ones
  typedef struct packed {
    logic [1:0] len;
    logic [7:0] c0;
    logic [7:0] c1;
    logic [7:0] c2;
  } lsc_reply_s;

endpackage

/* lsc_state_cmd.sv */
`timescale 1ns/1ps
// Summary of operation
// [R01] Level command selects high or low setpoint; query reports the selection.
// [R02] Low setpoint means current, resistance, voltage or power per operating mode.
// [R03] Dynamic on runs dynamic loading, off runs static; query reports setting.
// [R04] Clear command zeroes protection status and error registers.
// [R05] Fail query returns digit 0 or 1; fail indicator lit only for 1.
// [R06] Bit 0 over-power, 1 over-temperature, 2 over-voltage, 3 over-current.
// [R07] Protection query returns decimal sum of set bit weights, 8-bit word.
// [R08] Protection bits stay latched after a trip until the clear command.
module lsc_state_cmd
  import lsc_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              cmd_valid,
  input  wire lsc_pkg::lsc_cmd_e cmd_code,
  input  wire lsc_pkg::lsc_mode_e op_mode,
  input  wire lsc_pkg::lsc_trip_s trip_in,
  input  wire logic              err_set,
  input  wire logic [7:0]        err_code,
  input  wire logic              fail_in,
  output logic                   reply_valid,
  output lsc_pkg::lsc_reply_s    reply,
  output logic                   level_high,
  output lsc_pkg::lsc_sp_e       low_setpoint_kind,
  output logic                   dynamic_loading,
  output logic                   fail_led,
  output logic [7:0]             protection_trip_status,
  output logic [7:0]             error_status
);
  import lsc_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic lsc_reply_s one_digit(input logic b);
    lsc_reply_s r;
    r     = '0;
    r.len = 2'd1;
    r.c0  = b ? ASCII_ONE : ASCII_ZERO;
    return r;
  endfunction

  // Clear decode, used by the error group; the protection group decodes clear in its own case
  function automatic logic is_clear(input logic v, input lsc_cmd_e c);
    return v && (c == LSC_CMD_CLEAR);
  endfunction

  // Binary to decimal ASCII, leading zeros dropped
  function automatic lsc_reply_s dec_text(input logic [7:0] v);
    lsc_reply_s r;
    logic [7:0] h;
    logic [7:0] t;
    logic [7:0] o;
    r = '0;
    h = v / 8'd100;
    t = (v / 8'd10) % 8'd10;
    o = v % 8'd10;
    if (h != 8'h00)
    begin
      r.len = 2'd3;
      r.c0  = ASCII_ZERO + h;
      r.c1  = ASCII_ZERO + t;
      r.c2  = ASCII_ZERO + o;
    end
    else if (t != 8'h00)
    begin
      r.len = 2'd2;
      r.c0  = ASCII_ZERO + t;
      r.c1  = ASCII_ZERO + o;
    end
    else
    begin
      r.len = 2'd1;
      r.c0  = ASCII_ZERO + o;
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic       level_reg,   level_next;
  logic       dyn_reg,     dyn_next;
  logic [7:0] protection_trip_status_reg,    protection_trip_status_next;
  logic [7:0] err_reg,     err_next;
  logic       rvalid_reg,  rvalid_next;
  lsc_reply_s reply_reg,   reply_next;
  logic [7:0] trip_vec;

  // ---------------------------------------------------------------
  // Trip event mapping
  // ---------------------------------------------------------------
  always_comb
  begin
    trip_vec                 = '0;
    trip_vec[BIT_OVER_POWER] = trip_in.over_power_trip; // [R06]
    trip_vec[BIT_OVER_TEMP]  = trip_in.over_temp_trip;  // [R06]
    trip_vec[BIT_OVER_VOLT]  = trip_in.over_voltage_trip; // [R06]
    trip_vec[BIT_OVER_CURR]  = trip_in.over_current_trip; // [R06]
  end

  // ---------------------------------------------------------------
  // Command state and protection next values
  // ---------------------------------------------------------------
  always_comb
  begin
    level_next  = level_reg;
    dyn_next    = dyn_reg;
    protection_trip_status_next   = protection_trip_status_reg;
    rvalid_next = 1'b0;
    reply_next  = reply_reg;
    if (cmd_valid)
    begin
      case (cmd_code)
        LSC_CMD_LEVEL_HIGH:  level_next = 1'b1; // [R01]
        LSC_CMD_LEVEL_LOW:   level_next = 1'b0; // [R01]
        LSC_CMD_LEVEL_QUERY:
        begin
          rvalid_next = 1'b1;
          reply_next  = one_digit(level_reg); // [R01]
        end
        LSC_CMD_DYN_ON:      dyn_next = 1'b1; // [R03]
        LSC_CMD_DYN_OFF:     dyn_next = 1'b0; // [R03]
        LSC_CMD_DYN_QUERY:
        begin
          rvalid_next = 1'b1;
          reply_next  = one_digit(dyn_reg); // [R03]
        end
        LSC_CMD_CLEAR:
        begin
          protection_trip_status_next = PROTECTION_TRIP_STATUS_RESET; // [R04]
        end
        LSC_CMD_FAIL_QUERY:
        begin
          rvalid_next = 1'b1;
          reply_next  = one_digit(fail_in); // [R05]
        end
        LSC_CMD_PROTECTION_TRIP_STATUS_QUERY:
        begin
          rvalid_next = 1'b1;
          reply_next  = dec_text(protection_trip_status_reg); // [R07]
        end
        default: ;
      endcase
    end
    // Trips set after clear so an event in the clear cycle survives
    protection_trip_status_next = protection_trip_status_next | trip_vec; // [R08]
  end

  // ---------------------------------------------------------------
  // Command state registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      level_reg  <= 1'b0;
      dyn_reg    <= 1'b0;
      protection_trip_status_reg   <= PROTECTION_TRIP_STATUS_RESET;
      rvalid_reg <= 1'b0;
      reply_reg  <= '0;
    end
    else
    begin
      level_reg  <= level_next;
      dyn_reg    <= dyn_next;
      protection_trip_status_reg   <= protection_trip_status_next;
      rvalid_reg <= rvalid_next;
      reply_reg  <= reply_next;
    end
  end

  // ---------------------------------------------------------------
  // Error register
  // ---------------------------------------------------------------
  // Load wins over clear so an error raised in the clear cycle is kept
  always_comb
  begin
    err_next = err_reg;
    if (is_clear(cmd_valid, cmd_code))
    begin
      err_next = ERR_RESET; // [R04]
    end
    if (err_set)
    begin
      err_next = err_code;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      err_reg <= ERR_RESET;
    end
    else
    begin
      err_reg <= err_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_comb
  begin
    case (op_mode)
      LSC_MODE_CC: low_setpoint_kind = LSC_SP_CURRENT;    // [R02]
      LSC_MODE_CR: low_setpoint_kind = LSC_SP_RESISTANCE; // [R02]
      LSC_MODE_CV: low_setpoint_kind = LSC_SP_VOLTAGE;    // [R02]
      LSC_MODE_CP: low_setpoint_kind = LSC_SP_POWER;      // [R02]
      default:     low_setpoint_kind = LSC_SP_CURRENT;
    endcase
  end

  assign level_high             = level_reg;
  assign dynamic_loading        = dyn_reg; // [R03]
  assign fail_led               = fail_in; // [R05]
  assign protection_trip_status = protection_trip_status_reg;
  assign error_status           = err_reg;
  assign reply_valid            = rvalid_reg;
  assign reply                  = reply_reg;

endmodule

/* lsc_host_model.sv */
`timescale 1ns/1ps
module lsc_host_model
  import lsc_pkg::*;
(
  input  wire logic        ref_clk,
  output lsc_pkg::lsc_cmd_e cmd_code,
  output logic             cmd_valid
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code = LSC_CMD_NONE;
  end
  // Code goes back to none so a stale command is never seen
  task automatic send(input lsc_cmd_e c);
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_code = c;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    cmd_code = LSC_CMD_NONE;
  endtask
endmodule

/* lsc_state_cmd_properties.sv */
`timescale 1ns/1ps
module lsc_state_cmd_properties
  import lsc_pkg::*;
(
  input wire logic               ref_clk,
  input wire logic               rst,
  input wire logic               cmd_valid,
  input wire lsc_pkg::lsc_cmd_e  cmd_code,
  input wire lsc_pkg::lsc_mode_e op_mode,
  input wire lsc_pkg::lsc_trip_s trip_in,
  input wire logic               err_set,
  input wire logic               fail_in,
  input wire logic               reply_valid,
  input wire logic               level_high,
  input wire lsc_pkg::lsc_sp_e   low_setpoint_kind,
  input wire logic               dynamic_loading,
  input wire logic               fail_led,
  input wire logic [7:0]         protection_trip_status,
  input wire logic [7:0]         error_status
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_cmd(lsc_cmd_e c);
    cmd_valid && cmd_code == c;
  endsequence
  sequence s_clean_clear;
    s_cmd(LSC_CMD_CLEAR) ##0 (trip_in == 4'h0 && !err_set);
  endsequence
  chk_level_high: assert property (s_cmd(LSC_CMD_LEVEL_HIGH) |=> level_high) else $error("level");
  chk_dyn_off: assert property (s_cmd(LSC_CMD_DYN_OFF) |=> !dynamic_loading) else $error("dyn");
  chk_sp_kind: assert property ({low_setpoint_kind} == {op_mode}) else $error("kind");
  chk_clear_zero: assert property (s_clean_clear |=> protection_trip_status == 8'h00 && error_status == 8'h00)
    else $error("clear");
  chk_fail_led: assert property (fail_led == fail_in) else $error("led");
  chk_trip_bits: assert property (|trip_in |=> (protection_trip_status[3:0] & $past(trip_in)) == $past(trip_in))
    else $error("trip");
  chk_high_zero: assert property (protection_trip_status[7:4] == 4'h0) else $error("upper");
  chk_trip_hold: assert property (!(cmd_valid && cmd_code == LSC_CMD_CLEAR) |=>
    (protection_trip_status & $past(protection_trip_status)) == $past(protection_trip_status)) else $error("hold");
  chk_query_ans: assert property (s_cmd(LSC_CMD_PROTECTION_TRIP_STATUS_QUERY) |=> reply_valid) else $error("reply");
endmodule
bind lsc_state_cmd lsc_state_cmd_properties i_props (.*);

/* lsc_state_cmd_tb.sv */
`timescale 1ns/1ps
module lsc_state_cmd_tb;
  import lsc_pkg::*;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       cmd_valid;
  lsc_cmd_e   cmd_code;
  lsc_mode_e  op_mode = LSC_MODE_CC;
  lsc_trip_s  trip_in = 4'h0;
  logic       err_set = 1'b0;
  logic [7:0] err_code = 8'h00;
  logic       fail_in = 1'b0;
  logic       reply_valid;
  lsc_reply_s reply;
  logic       level_high;
  lsc_sp_e    low_setpoint_kind;
  logic       dynamic_loading;
  logic       fail_led;
  logic [7:0] protection_trip_status;
  logic [7:0] error_status;
  int         miscompares = 0;
  int         num_checks = 0;
  int         cyc = 0;
  always #2 ref_clk = ~ref_clk;
  lsc_state_cmd i_lsc_state_cmd (.*);
  lsc_host_model i_lsc_host_model (.*);
  task automatic chk(input string nm, input logic [26:0] seen, input logic [26:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [25:0] dig(input logic [7:0] c);
    return {2'h1, c, 16'h0000};
  endfunction
  task automatic ask(input lsc_cmd_e c, input logic [25:0] exp);
    i_lsc_host_model.send(c);
    chk("reply", {reply_valid, reply}, {1'b1, exp});
  endtask
  task automatic t_state;
    i_lsc_host_model.send(LSC_CMD_LEVEL_HIGH);
    ask(LSC_CMD_LEVEL_QUERY, dig(ASCII_ONE));
    i_lsc_host_model.send(LSC_CMD_LEVEL_LOW);
    chk("level", level_high, 1'b0);
    ask(LSC_CMD_LEVEL_QUERY, dig(ASCII_ZERO));
    i_lsc_host_model.send(LSC_CMD_DYN_ON);
    chk("dyn", dynamic_loading, 1'b1);
    ask(LSC_CMD_DYN_QUERY, dig(ASCII_ONE));
    i_lsc_host_model.send(LSC_CMD_DYN_OFF);
    ask(LSC_CMD_DYN_QUERY, dig(ASCII_ZERO));
    $display("state done");
  endtask
  task automatic t_mode;
    for (int i = 0; i < 4; i++)
    begin
      op_mode = lsc_mode_e'(i);
      #1;
      chk("kind", low_setpoint_kind, 27'(i));
    end
    $display("mode done");
  endtask
  task automatic t_fail;
    fail_in = 1'b1;
    #1;
    chk("led", fail_led, 1'b1);
    ask(LSC_CMD_FAIL_QUERY, dig(ASCII_ONE));
    fail_in = 1'b0;
    ask(LSC_CMD_FAIL_QUERY, dig(ASCII_ZERO));
    $display("fail done");
  endtask
  task automatic t_protection_trip_status;
    for (int i = 0; i < 4; i++)
    begin
      trip_in = lsc_trip_s'(4'h1 << i);
      @(posedge ref_clk);
      #1;
      trip_in = 4'h0;
      @(posedge ref_clk);
      #1;
    end
    chk("protection_trip_status", protection_trip_status, 8'h0f);
    ask(LSC_CMD_PROTECTION_TRIP_STATUS_QUERY, {2'h2, ASCII_ONE, 8'h35, 8'h00});
    err_set = 1'b1;
    err_code = 8'ha5;
    @(posedge ref_clk);
    #1;
    err_set = 1'b0;
    chk("err", error_status, 8'ha5);
    i_lsc_host_model.send(LSC_CMD_CLEAR);
    chk("protection_trip_status", protection_trip_status, 8'h00);
    chk("err", error_status, 8'h00);
    ask(LSC_CMD_PROTECTION_TRIP_STATUS_QUERY, dig(ASCII_ZERO));
    $display("protection_trip_status done");
  endtask
  task automatic end_sim;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc > 500)
    begin
      miscompares++;
      end_sim;
    end
  end
  initial
  begin
    repeat (6) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    t_state;
    t_mode;
    t_fail;
    t_protection_trip_status;
    end_sim;
  end
endmodule
